//--- rtl/pci_pm_capability_regs.sv
`timescale 1ns/1ps
`include "pm_cap_defines.svh"

module pci_pm_capability_regs
  import pm_cap_pkg::*;
#(
  parameter int NUM_FUNCTIONS = 3
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // Build strap from a pin: high selects the S3 build of the enhanced function
  input wire logic S3_STRAP,
  // Configuration access request
  input wire logic CFG_REQ,
  input wire logic CFG_WRITE,
  input wire logic [1:0] CFG_FUNC,
  input wire logic [7:0] CFG_ADDR,
  input wire logic [3:0] CFG_BYTE_EN,
  input wire logic [31:0] CFG_WDATA,
  // Configuration access answer
  output logic CFG_ACK,
  output logic [31:0] CFG_RDATA,
  output logic CFG_UNSUPPORTED,
  output logic CFG_WR_DROPPED
);

  regs_state_t r_r;
  regs_state_t r_nxt;
  logic [15:0] caps_words [NUM_FUNCTIONS];

  // Which dword of configuration space an address falls in
  function automatic cfg_region_t region_of(input logic [7:0] addr);
    cfg_region_t rg;
    rg = RG_NONE;
    if (addr[7:2] == 6'(`CAP_PTR_ADDR >> 2)) begin
      rg = RG_CAP_PTR;
    end else if (addr[7:2] == 6'(`PM_CAP_BASE >> 2)) begin
      rg = RG_PM;
    end
    return rg;
  endfunction

  // Expand byte enables into a bit mask for the dword
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{be[b]}};
    end
    return m;
  endfunction

  // True when the function number names one of ours
  function automatic logic fn_present(input logic [1:0] fn);
    return 32'(fn) < NUM_FUNCTIONS;
  endfunction

  // One capabilities generator per function
  genvar gi;
  generate
    for (gi = 0; gi < NUM_FUNCTIONS; gi++) begin : g_fn
      pmc_if caps_if ();
      assign caps_if.fn = 2'(gi);
      assign caps_if.s3_variant = r_r.s3_variant;
      pm_cap_word u_word (
        .p(caps_if)
      );
      assign caps_words[gi] = caps_if.word;
    end
  endgenerate

  logic [31:0] pm_dword;
  logic [31:0] read_word;
  logic [15:0] sel_caps;
  cfg_region_t req_region;

  always_comb begin
    sel_caps = 16'h0000;
    if (fn_present(CFG_FUNC)) begin
      sel_caps = caps_words[CFG_FUNC];
    end
    req_region = region_of(CFG_ADDR);
    pm_dword = 32'h0000_0000;
    pm_dword[`PM_CAPABILITY_IDENTIFIER_OFFSET*8 +: 8] = `PM_CAPABILITY_IDENTIFIER_VALUE;
    pm_dword[`PM_NEXT_PTR_OFFSET*8 +: 8] = `PM_NEXT_PTR_VALUE;
    pm_dword[`PM_CAPS_OFFSET*8 +: 16] = sel_caps;
    unique case (req_region)
      RG_CAP_PTR: begin
        read_word = {24'h00_0000, `PM_CAP_BASE};
      end
      RG_PM: begin
        read_word = pm_dword;
      end
      RG_NONE: begin
        read_word = 32'h0000_0000;
      end
      default: begin
        read_word = 32'h0000_0000;
      end
    endcase
  end

  always_comb begin
    r_nxt = r_r;
    r_nxt.ack = 1'b0;
    r_nxt.unsupported = 1'b0;
    r_nxt.wr_dropped = 1'b0;

    // Strap passes two flops; the build is frozen once after reset so the
    // capabilities cannot change under software's feet
    // The sync stages restart at zero, so wait until stage two holds a sample
    r_nxt.strap_sync = {r_r.strap_sync[0], S3_STRAP};
    if (r_r.strap_age != `STRAP_DONE_AGE) begin
      r_nxt.strap_age = r_r.strap_age + 2'h1;
    end
    if (r_r.strap_age == `STRAP_TAKE_AGE) begin
      r_nxt.s3_variant = r_r.strap_sync[1];
    end

    unique case (r_r.st)
      BUS_IDLE: begin
        if (CFG_REQ) begin
          r_nxt.st = BUS_ANSWER;
          r_nxt.ack = 1'b1;
          r_nxt.unsupported = !fn_present(CFG_FUNC);
          if (CFG_WRITE) begin
            // Write is acknowledged, nothing here is writable
            r_nxt.rdata = 32'h0000_0000;
            r_nxt.wr_dropped = fn_present(CFG_FUNC) && (req_region == RG_PM) &&
                               (|CFG_BYTE_EN[3:1]) && (|CFG_WDATA);
          end else if (fn_present(CFG_FUNC)) begin
            r_nxt.rdata = read_word & lane_mask(CFG_BYTE_EN);
          end else begin
            r_nxt.rdata = 32'h0000_0000;
          end
        end
      end
      BUS_ANSWER: begin
        // One dead cycle between answers keeps the port single-outstanding
        r_nxt.st = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      r_r <= '{st: BUS_IDLE, ack: 1'b0, unsupported: 1'b0, wr_dropped: 1'b0,
               rdata: 32'h0000_0000, strap_sync: 2'h0, strap_age: 2'h0,
               s3_variant: 1'b0};
    end else begin
      r_r <= r_nxt;
    end
  end

  assign CFG_ACK = r_r.ack;
  assign CFG_RDATA = r_r.rdata;
  assign CFG_UNSUPPORTED = r_r.unsupported;
  assign CFG_WR_DROPPED = r_r.wr_dropped;

endmodule

//--- rtl/pm_cap_defines.svh
`ifndef PM_CAP_DEFINES_SVH
`define PM_CAP_DEFINES_SVH

// Configuration space layout, byte addresses
`define CAP_PTR_ADDR 8'h34
`define PM_CAP_BASE 8'h50
`define PM_CAPABILITY_IDENTIFIER_OFFSET 8'h00
`define PM_NEXT_PTR_OFFSET 8'h01
`define PM_CAPS_OFFSET 8'h02

// Fixed register contents
`define PM_CAPABILITY_IDENTIFIER_VALUE 8'h01
`define PM_NEXT_PTR_VALUE 8'h00
`define PM_SPEC_VERSION 3'h2

// Field positions inside power_capabilities
`define WAKE_MASK_MSB 15
`define WAKE_MASK_LSB 11
`define WAKE_D3COLD_BIT 15
`define WAKE_D3HOT_BIT 14
`define WAKE_D2_BIT 13
`define WAKE_D1_BIT 12
`define WAKE_D0_BIT 11
`define DEEP_SLEEP_BIT 10
`define LIGHT_SLEEP_BIT 9
`define AUX_CURRENT_MSB 8
`define AUX_CURRENT_LSB 6
`define DSI_BIT 5
`define CAPS_RSVD_BIT 4
`define PM_VERSION_MSB 2
`define PM_VERSION_LSB 0

// Timing of the configuration port, in PCI clock cycles
`define CFG_ANSWER_CYCLES 1

// Strap age after reset at which the second sync stage holds a real sample
`define STRAP_TAKE_AGE 2'h2
`define STRAP_DONE_AGE 2'h3

`endif

//--- rtl/pm_cap_pkg.sv
package pm_cap_pkg;

  typedef enum logic [1:0] {
    FN_LEGACY_ONE = 2'h0,
    FN_LEGACY_TWO = 2'h1,
    FN_ENHANCED = 2'h2
  } host_fn_t;

  typedef enum logic [1:0] {
    RG_NONE = 2'h0,
    RG_CAP_PTR = 2'h1,
    RG_PM = 2'h2
  } cfg_region_t;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ANSWER = 1'b1
  } bus_state_t;

  typedef struct packed {
    bus_state_t st;
    logic ack;
    logic unsupported;
    logic wr_dropped;
    logic [31:0] rdata;
    logic [1:0] strap_sync;
    logic [1:0] strap_age;
    logic s3_variant;
  } regs_state_t;

endpackage

//--- rtl/pmc_if.sv
`timescale 1ns/1ps
interface pmc_if;
  logic [1:0] fn;
  logic s3_variant;
  logic [15:0] word;

  modport query (output fn, output s3_variant, input word);
  modport answer (input fn, input s3_variant, output word);
endinterface

//--- rtl/pm_cap_word.sv
`timescale 1ns/1ps
`include "pm_cap_defines.svh"

module pm_cap_word
  import pm_cap_pkg::*;
(
  // Function identity in, capabilities word out
  pmc_if.answer p
);

  logic enhanced;
  logic d3cold_wake;

  always_comb begin
    enhanced = (p.fn == FN_ENHANCED);
    // Only the enhanced function in its S3 build wakes from D3cold
    d3cold_wake = enhanced & p.s3_variant;
    p.word = 16'h0000;
    p.word[`WAKE_D3COLD_BIT] = d3cold_wake;
    p.word[`WAKE_D3HOT_BIT] = 1'b1;
    p.word[`WAKE_D2_BIT] = enhanced;
    p.word[`WAKE_D1_BIT] = 1'b1;
    p.word[`WAKE_D0_BIT] = enhanced;
    p.word[`DEEP_SLEEP_BIT] = enhanced;
    p.word[`LIGHT_SLEEP_BIT] = 1'b1;
    // Aux current is forced to zero whenever D3cold wake is absent
    // Only the field's top bit varies, so bits 7 and 6 keep their fixed zero
    p.word[`AUX_CURRENT_MSB:`AUX_CURRENT_LSB] = {d3cold_wake, 2'h0};
    p.word[`DSI_BIT] = 1'b0;
    p.word[`CAPS_RSVD_BIT] = 1'b0;
    p.word[`PM_VERSION_MSB:`PM_VERSION_LSB] = `PM_SPEC_VERSION;
  end

endmodule

//--- test/pm_cap_asserts.sv
`timescale 1ns/1ps
module pm_cap_asserts (
  // Clock, reset, strap
  input wire logic CLK, NRST, S3_STRAP,
  // Request
  input wire logic CFG_REQ, CFG_WRITE,
  input wire logic [1:0] CFG_FUNC,
  input wire logic [7:0] CFG_ADDR,
  input wire logic [3:0] CFG_BYTE_EN,
  input wire logic [31:0] CFG_WDATA,
  // Answer
  input wire logic CFG_ACK, CFG_UNSUPPORTED, CFG_WR_DROPPED,
  input wire logic [31:0] CFG_RDATA
);
  logic pm_r, wr_r;
  logic [1:0] fn_r;
  wire rd_ok = CFG_ACK && pm_r && !wr_r;
  // Remember what was taken so the answer can be tied back to it
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pm_r <= 1'b0;
      wr_r <= 1'b0;
      fn_r <= 2'h0;
    end else begin
      pm_r <= CFG_REQ && !CFG_ACK && CFG_ADDR[7:2] == 6'h14 && CFG_BYTE_EN == 4'hf
        && CFG_FUNC != 2'h3;
      wr_r <= CFG_WRITE;
      fn_r <= CFG_FUNC;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  property p_next_ptr; rd_ok |-> CFG_RDATA[15:8] == 8'h00; endproperty
  a_next_ptr: assert property (p_next_ptr) else $error("next pointer not zero");
  property p_capability_identifier; rd_ok |-> CFG_RDATA[7:0] == 8'h01; endproperty
  a_capability_identifier: assert property (p_capability_identifier) else $error("capability id wrong");
  property p_low; rd_ok |-> CFG_RDATA[23:16] == 8'h02; endproperty
  a_low: assert property (p_low) else $error("low capability byte wrong");
  property p_deep; rd_ok |-> CFG_RDATA[26] == (fn_r == 2'h2); endproperty
  a_deep: assert property (p_deep) else $error("deep sleep bit wrong");
  property p_light; rd_ok |-> CFG_RDATA[25]; endproperty
  a_light: assert property (p_light) else $error("light sleep bit wrong");
  property p_cold; rd_ok && fn_r != 2'h2 |-> !CFG_RDATA[31]; endproperty
  a_cold: assert property (p_cold) else $error("legacy claims cold wake");
  property p_aux; rd_ok && !CFG_RDATA[31] |-> CFG_RDATA[24:22] == 3'h0; endproperty
  a_aux: assert property (p_aux) else $error("aux current not zero");
  property p_wake; rd_ok |-> CFG_RDATA[30] && CFG_RDATA[28]; endproperty
  a_wake: assert property (p_wake) else $error("wake mask wrong");
  property p_write; CFG_ACK && wr_r |-> CFG_RDATA == 32'h0 ##1 !CFG_ACK; endproperty
  a_write: assert property (p_write) else $error("write answer wrong");
  property p_answer; CFG_REQ && !CFG_ACK |=> CFG_ACK; endproperty
  a_answer: assert property (p_answer) else $error("request not answered");
endmodule

//--- test/pm_host_model.sv
`timescale 1ns/1ps
module pm_host_model (
  // Clock and answer
  input wire logic clk,
  input wire logic ack,
  input wire logic uns,
  input wire logic drop,
  input wire logic [31:0] rdata,
  // Request
  output logic req,
  output logic wr,
  output logic [1:0] fn,
  output logic [7:0] addr,
  output logic [3:0] be,
  output logic [31:0] wdata
);
  initial begin
    req = 0; wr = 0; fn = 0; addr = 0; be = 0; wdata = 0;
  end
  // Held until acknowledge; on release addr and wdata show inverted junk, not the old value
  task automatic xfer(input logic w, input logic [1:0] f, input logic [7:0] a,
    input logic [3:0] b, output logic ok, output logic [33:0] res);
    int n;
    @(posedge clk);
    #1;
    req = 1; wr = w; fn = f; addr = a; be = b; wdata = 32'hffff_ffff;
    n = 0; ok = 0; res = 0;
    while (!ok && n < 8) begin
      @(posedge clk);
      #1;
      ok = ack;
      res = {drop, uns, rdata};
      n++;
    end
    // Hold through the edge at which the registered answer stands
    @(posedge clk);
    #1;
    req = 0; addr = ~a; wdata = ~wdata;
  endtask
endmodule

//--- test/pci_pm_capability_regs_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module pci_pm_capability_regs_tb_top;
  logic clk, nrst, strap, req, wr, ack, uns, drop;
  logic [1:0] fn;
  logic [7:0] addr;
  logic [3:0] be;
  logic [31:0] wdata, rdata;
  int miscompares = 0;
  int checks_done = 0;
  pci_pm_capability_regs pci_pm_capability_regs_i (.CLK(clk), .NRST(nrst), .S3_STRAP(strap),
    .CFG_REQ(req), .CFG_WRITE(wr), .CFG_FUNC(fn), .CFG_ADDR(addr), .CFG_BYTE_EN(be),
    .CFG_WDATA(wdata), .CFG_ACK(ack), .CFG_RDATA(rdata), .CFG_UNSUPPORTED(uns),
    .CFG_WR_DROPPED(drop));
  pm_host_model pm_host_model_i (.clk(clk), .ack(ack), .uns(uns), .drop(drop), .rdata(rdata),
    .req(req), .wr(wr), .fn(fn), .addr(addr), .be(be), .wdata(wdata));
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  task automatic do_reset(input logic s);
    @(posedge clk);
    #1 strap = s;
    nrst = 0;
    repeat (16) @(posedge clk);
    #1 nrst = 1;
    repeat (3) @(posedge clk);
  endtask
  task automatic rd(input logic w, input logic [1:0] f, input logic [7:0] a,
    input logic [3:0] b, input logic [33:0] e);
    logic ok;
    logic [33:0] r;
    pm_host_model_i.xfer(w, f, a, b, ok, r);
    `CHK("ack", 1'b1, ok)
    `CHK("answer", e, r)
  endtask
  task automatic t_reads;
    for (int f = 0; f < 3; f++) begin
      rd(0, 2'(f), 8'h50, 4'hf, {2'b00, (f == 2) ? 16'h7e02 : 16'h5202, 16'h0001});
      rd(0, 2'(f), 8'h53, 4'hc, {2'b00, (f == 2) ? 16'h7e02 : 16'h5202, 16'h0000});
      rd(0, 2'(f), 8'h34, 4'hf, 34'h50);
    end
  endtask
  task automatic t_writes;
    rd(1, 2'h2, 8'h50, 4'hf, {2'b10, 32'h0});
    rd(0, 2'h2, 8'h50, 4'hf, {2'b00, 32'h7e020001});
    rd(1, 2'h0, 8'h34, 4'hf, {2'b00, 32'h0});
    rd(0, 2'h0, 8'h50, 4'h3, {2'b00, 32'h00000001});
  endtask
  task automatic t_absent;
    rd(0, 2'h3, 8'h50, 4'hf, {2'b01, 32'h0});
  endtask
  task automatic t_s3;
    rd(0, 2'h2, 8'h50, 4'hf, {2'b00, 32'hff020001});
    rd(0, 2'h1, 8'h50, 4'hf, {2'b00, 32'h52020001});
  endtask
  task give_verdict;
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Whole run is under a hundred cycles; this span leaves a wide margin
  initial begin
    #400000;
    miscompares++;
    give_verdict;
  end
  initial begin
    nrst = 0;
    strap = 0;
    do_reset(1'b0);
    t_reads;
    t_writes;
    t_absent;
    do_reset(1'b1);
    t_s3;
    give_verdict;
  end
endmodule
bind pci_pm_capability_regs pm_cap_asserts pm_cap_asserts_i (.CLK, .NRST, .S3_STRAP, .CFG_REQ,
  .CFG_WRITE, .CFG_FUNC, .CFG_ADDR, .CFG_BYTE_EN, .CFG_WDATA, .CFG_ACK, .CFG_UNSUPPORTED,
  .CFG_WR_DROPPED, .CFG_RDATA);
